/* File: common/uctl_pkg.sv */
`default_nettype none
package uctl_pkg;
   // Register byte addresses
   localparam logic [4:0] UCTL_STATUS = 5'h00;
   localparam logic [4:0] UCTL_CTRL1  = 5'h04;
   localparam logic [4:0] UCTL_CTRL2  = 5'h08;
   localparam logic [4:0] UCTL_CTRL3  = 5'h0C;
   localparam logic [4:0] UCTL_DATA   = 5'h10;
   localparam logic [4:0] UCTL_BAUD   = 5'h14;
   // uart_control_one fields
   localparam int C1_ON    = 7;
   localparam int C1_LEN   = 6;
   localparam int C1_PAR   = 5;
   localparam int C1_ODD   = 4;
   localparam int C1_STOP2 = 3;
   localparam int C1_BRK   = 2;
   localparam int C1_TX9   = 0;
   // uart_control_two fields
   localparam int C2_TXON  = 7;
   localparam int C2_RXON  = 6;
   localparam int C2_SPD   = 5;
   localparam int C2_ADDR  = 4;
   localparam int C2_WAKE  = 3;
   localparam int C2_RIE   = 2;
   localparam int C2_TX_IDLE_IRQ_ENABLE  = 1;
   localparam int C2_TX_EMPTY_IRQ_ENABLE  = 0;
   // Reset values and timing
   localparam logic [7:0] UCTL_CTRL_RST = 8'h00;
   localparam logic [7:0] UCTL_BAUD_RST = 8'h00;
   localparam logic [3:0] UCTL_BREAK_BITS = 4'hD;
   localparam int UCTL_SHIFT_HIGH = 4;
   localparam int UCTL_SHIFT_LOW  = 6;
   // Pin carrier
   typedef struct packed {
      logic tx_out;
      logic tx_oe;
      logic rxtx_out;
      logic rxtx_oe;
   } uctl_pins_s;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BRK} uctl_tx_e;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uctl_rx_e;
endpackage : uctl_pkg
`default_nettype wire

/* File: hdl/uctl_top.sv */
// Overview of operation
// - Global off floats pins, disables UART
// - Disable empties buffer, resets baud counter
// - Disable clears enables/errors, sets idle flags
// - Disable aborts activity; config kept
// - Length select: 8 or 9 bits
// - Parity on/off, even or odd
// - Transmitter sends one or two stop_count_select
// - Break holds line low, thirteen bits minimum
// - Transmit off aborts, floats transmit pin
// - Receive off aborts; receive on floats shared pin
// - Speed select picks high/low baud mode
// - Address bit zero words discarded silently
// - Wake only when clock off, enabled
// - Receive/overrun raise request when enabled
// - Transmit idle raises request when enabled
// - Transmit empty raises request when enabled
// - Single wire pin role from enables
// - Bit period (divisor + 1) times 16 or 64
// - Receiver checks only one stop bit
//
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module uctl_top import uctl_pkg::*; (
   input  wire logic        clk_in,    // System clock
   input  wire logic        rst_n_in,  // Async reset, low
   input  wire logic        cyc_in,    // Wishbone cycle
   input  wire logic        stb_in,    // Wishbone strobe
   input  wire logic        we_in,     // Wishbone write
   input  wire logic [4:0]  adr_in,    // Byte address
   input  wire logic [3:0]  sel_in,    // Byte selects
   input  wire logic [31:0] dat_in,    // Write data
   output logic      [31:0] dat_out,   // Read data
   output logic             ack_out,   // Wishbone ack
   input  wire logic        rxtx_in,   // Shared pin level
   input  wire logic        fh_off_in, // UART clock gated off
   output uctl_pins_s       pins_out,  // Pin drives
   output logic             irq_out,   // Interrupt request
   output logic             wake_out   // Wake-up request
);
   logic [1:0]  rst_q;
   logic        rst_n;
   logic [7:0]  c1;
   logic [7:0]  c2;
   logic        single_wire_select;
   logic [7:0]  baud;
   logic        on, transmitter_on, receiver_on, acc, wr, rd, st_rd;
   logic [14:0] bit_len;
   logic [3:0]  nbits;
   uctl_tx_e    tx_st;
   logic [8:0]  tx_buf, tx_sh;
   logic        tx_full, tx_line, tx_par;
   logic [3:0]  tx_cnt;
   logic [14:0] tx_tmr;
   logic        transmit_idle_flag, txe;
   uctl_rx_e    rx_st;
   logic [8:0]  rx_sh;
   logic [3:0]  rx_cnt;
   logic [14:0] rx_tmr;
   logic        rx_par, rx_pbad, rx_q;
   logic [7:0]  rx_data;
   logic        rx9, rxav, ov, fe, pe;

   // Reset release through two flops
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) rst_q <= 2'h0;
      else rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_n = rst_q[1];

   // Enables and bit timing
   assign on    = c1[C1_ON];
   assign transmitter_on  = on & c2[C2_TXON];
   assign receiver_on  = on & c2[C2_RXON];
   assign nbits = c1[C1_LEN] ? 4'h9 : 4'h8;
   assign bit_len = c2[C2_SPD] ? ({7'h00, baud} + 15'h0001) << UCTL_SHIFT_HIGH
                               : ({7'h00, baud} + 15'h0001) << UCTL_SHIFT_LOW;

   // Bus access decode
   assign acc = cyc_in & stb_in & ack_out;
   assign wr  = acc & we_in & sel_in[0];
   assign rd  = acc & ~we_in;

   // Wishbone ack and read data
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         ack_out <= 1'b0;
         dat_out <= 32'h00000000;
      end else begin
         ack_out <= cyc_in & stb_in & ~ack_out;
         if (cyc_in & stb_in & ~ack_out & ~we_in) begin
            unique case (adr_in)
               UCTL_STATUS: dat_out <= {24'h000000, pe, 1'b0, fe, ov,
                                        rx_st == RX_IDLE, rxav, transmit_idle_flag, txe};
               UCTL_CTRL1:  dat_out <= {24'h000000, c1[7:2], rx9, 1'b0};
               UCTL_CTRL2:  dat_out <= {24'h000000, c2};
               UCTL_CTRL3:  dat_out <= {31'h00000000, single_wire_select};
               UCTL_DATA:   dat_out <= {24'h000000, rx_data};
               UCTL_BAUD:   dat_out <= {24'h000000, baud};
               default:     dat_out <= 32'h00000000;
            endcase
         end
      end
   end

   // Status-read then data-access clear sequence
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) st_rd <= 1'b0;
      else if (acc && adr_in == UCTL_DATA) st_rd <= 1'b0;
      else if (rd && adr_in == UCTL_STATUS) st_rd <= 1'b1;
   end

   // Control registers; global off clears enables and break
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         c1   <= UCTL_CTRL_RST;
         c2   <= UCTL_CTRL_RST;
         single_wire_select  <= 1'b0;
         baud <= UCTL_BAUD_RST;
      end else begin
         if (wr && adr_in == UCTL_CTRL1) c1 <= {dat_in[7:2], 1'b0, dat_in[0]};
         if (wr && adr_in == UCTL_CTRL2) c2 <= dat_in[7:0];
         if (wr && adr_in == UCTL_CTRL3) single_wire_select <= dat_in[0];
         if (wr && adr_in == UCTL_BAUD) baud <= dat_in[7:0];
         if (!on) begin
            c2[C2_TXON] <= 1'b0;
            c2[C2_RXON] <= 1'b0;
            c1[C1_BRK]  <= 1'b0;
         end
      end
   end

   // Transmitter
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         tx_st   <= TX_IDLE;
         tx_full <= 1'b0;
         tx_line <= 1'b1;
         tx_buf  <= 9'h000;
         tx_sh   <= 9'h000;
         tx_cnt  <= 4'h0;
         tx_tmr  <= 15'h0000;
         tx_par  <= 1'b0;
      end else if (!transmitter_on) begin
         tx_st   <= TX_IDLE;
         tx_full <= 1'b0;
         tx_line <= 1'b1;
         tx_tmr  <= 15'h0000;
      end else begin
         unique case (tx_st)
            TX_IDLE: begin
               if (tx_full) begin
                  tx_sh   <= tx_buf;
                  tx_full <= 1'b0;
                  tx_st   <= TX_START;
                  tx_line <= 1'b0;
                  tx_par  <= c1[C1_ODD];
                  tx_tmr  <= bit_len - 15'h0001;
               end else if (c1[C1_BRK]) begin
                  tx_st   <= TX_BRK;
                  tx_line <= 1'b0;
                  tx_cnt  <= 4'h0;
                  tx_tmr  <= bit_len - 15'h0001;
               end
            end
            default: begin
               if (tx_tmr != 15'h0000) tx_tmr <= tx_tmr - 15'h0001;
               else begin
                  tx_tmr <= bit_len - 15'h0001;
                  unique case (tx_st)
                     TX_START: begin
                        tx_st   <= TX_DATA;
                        tx_line <= tx_sh[0];
                        tx_par  <= tx_par ^ tx_sh[0];
                        tx_sh   <= tx_sh >> 1;
                        tx_cnt  <= 4'h0;
                     end
                     TX_DATA: begin
                        if (tx_cnt == nbits - 4'h1) begin
                           tx_cnt  <= 4'h0;
                           tx_st   <= c1[C1_PAR] ? TX_PAR : TX_STOP;
                           tx_line <= c1[C1_PAR] ? tx_par : 1'b1;
                        end else begin
                           tx_cnt  <= tx_cnt + 4'h1;
                           tx_line <= tx_sh[0];
                           tx_par  <= tx_par ^ tx_sh[0];
                           tx_sh   <= tx_sh >> 1;
                        end
                     end
                     TX_PAR: begin
                        tx_st   <= TX_STOP;
                        tx_line <= 1'b1;
                     end
                     TX_STOP: begin
                        if (c1[C1_STOP2] && tx_cnt == 4'h0) tx_cnt <= 4'h1;
                        else tx_st <= TX_IDLE;
                     end
                     TX_BRK: begin
                        if (tx_cnt < UCTL_BREAK_BITS) tx_cnt <= tx_cnt + 4'h1;
                        else if (!c1[C1_BRK]) begin
                           tx_st   <= TX_IDLE;
                           tx_line <= 1'b1;
                        end
                     end
                     default: tx_st <= TX_IDLE;
                  endcase
               end
            end
         endcase
         // Data write fills the holding buffer
         if (wr && adr_in == UCTL_DATA) begin
            tx_buf  <= {c1[C1_TX9], dat_in[7:0]};
            tx_full <= 1'b1;
         end
      end
   end
   assign txe   = ~tx_full;
   assign transmit_idle_flag = (tx_st == TX_IDLE) & ~tx_full & ~(transmitter_on & c1[C1_BRK]);

   // Receiver and receive flags
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         rx_st   <= RX_IDLE;
         rx_sh   <= 9'h000;
         rx_cnt  <= 4'h0;
         rx_tmr  <= 15'h0000;
         rx_par  <= 1'b0;
         rx_pbad <= 1'b0;
         rx_data <= 8'h00;
         rx9     <= 1'b0;
         rxav    <= 1'b0;
         ov      <= 1'b0;
         fe      <= 1'b0;
         pe      <= 1'b0;
      end else if (!receiver_on) begin
         rx_st  <= RX_IDLE;
         rx_tmr <= 15'h0000;
         rxav   <= 1'b0;
         ov     <= 1'b0;
         fe     <= 1'b0;
         pe     <= 1'b0;
      end else begin
         if (rd && st_rd && adr_in == UCTL_DATA) begin
            rxav <= 1'b0;
            ov   <= 1'b0;
            fe   <= 1'b0;
            pe   <= 1'b0;
         end
         if (rx_st == RX_IDLE) begin
            if (rx_q && !rxtx_in) begin
               rx_st  <= RX_START;
               rx_tmr <= bit_len >> 1;
            end
         end else if (rx_tmr != 15'h0000) rx_tmr <= rx_tmr - 15'h0001;
         else begin
            rx_tmr <= bit_len - 15'h0001;
            unique case (rx_st)
               RX_START: begin
                  rx_st   <= rxtx_in ? RX_IDLE : RX_DATA;
                  rx_cnt  <= 4'h0;
                  rx_par  <= c1[C1_ODD];
                  rx_pbad <= 1'b0;
               end
               RX_DATA: begin
                  rx_sh  <= {rxtx_in, rx_sh[8:1]};
                  rx_par <= rx_par ^ rxtx_in;
                  rx_cnt <= rx_cnt + 4'h1;
                  if (rx_cnt == nbits - 4'h1) rx_st <= c1[C1_PAR] ? RX_PAR : RX_STOP;
               end
               RX_PAR: begin
                  rx_pbad <= rxtx_in ^ rx_par;
                  rx_st   <= RX_STOP;
               end
               RX_STOP: begin
                  rx_st <= RX_IDLE;
                  if (!(c2[C2_ADDR] && !rx_sh[8])) begin
                     if (rxav) ov <= 1'b1;
                     else begin
                        rxav    <= 1'b1;
                        rx_data <= c1[C1_LEN] ? rx_sh[7:0] : rx_sh[8:1];
                        rx9     <= c1[C1_LEN] & rx_sh[8];
                        fe      <= ~rxtx_in;
                        pe      <= rx_pbad;
                     end
                  end
               end
               default: rx_st <= RX_IDLE;
            endcase
         end
      end
   end

   // Previous pin level and wake request
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         rx_q     <= 1'b1;
         wake_out <= 1'b0;
      end else begin
         rx_q <= rxtx_in;
         if (!fh_off_in) wake_out <= 1'b0;
         else if (c2[C2_WAKE] && rx_q && !rxtx_in) wake_out <= 1'b1;
      end
   end

   // Interrupt and pin drives
   assign irq_out = (c2[C2_RIE] & (rxav | ov)) | (c2[C2_TX_IDLE_IRQ_ENABLE] & transmit_idle_flag)
                  | (c2[C2_TX_EMPTY_IRQ_ENABLE] & txe) | wake_out;
   assign pins_out.tx_out   = tx_line;
   assign pins_out.tx_oe    = transmitter_on;
   assign pins_out.rxtx_out = tx_line;
   assign pins_out.rxtx_oe  = transmitter_on & single_wire_select & ~c2[C2_RXON];

   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n);
   property p_float;
      !on |-> !pins_out.tx_oe && !pins_out.rxtx_oe;
   endproperty
   a_float: assert property (p_float) else $error("pins driven while off");
   property p_off_flags;
      $fell(on) |=> !rxav && !ov && transmit_idle_flag && txe && rx_st == RX_IDLE;
   endproperty
   a_off_flags: assert property (p_off_flags) else $error("flags wrong after off");
   property p_txoff;
      !transmitter_on |=> tx_st == TX_IDLE && !tx_full && tx_line;
   endproperty
   a_txoff: assert property (p_txoff) else $error("transmitter not reset");
   property p_rxoff;
      !receiver_on |=> rx_st == RX_IDLE && !rxav;
   endproperty
   a_rxoff: assert property (p_rxoff) else $error("receiver not reset");
   property p_break;
      tx_st == TX_BRK && tx_cnt < UCTL_BREAK_BITS && transmitter_on |=> tx_st == TX_BRK && !tx_line;
   endproperty
   a_break: assert property (p_break) else $error("break ended early");
   property p_swm;
      pins_out.rxtx_oe |-> single_wire_select && !receiver_on && transmitter_on;
   endproperty
   a_swm: assert property (p_swm) else $error("shared pin role wrong");
   property p_irq_rx;
      c2[C2_RIE] && (rxav || ov) |-> irq_out;
   endproperty
   a_irq_rx: assert property (p_irq_rx) else $error("receive irq missing");
   property p_irq_te;
      c2[C2_TX_EMPTY_IRQ_ENABLE] && !tx_full |-> irq_out;
   endproperty
   a_irq_te: assert property (p_irq_te) else $error("empty irq missing");
   property p_irq_quiet;
      c2[3:0] == 4'h0 && !wake_out |-> !irq_out;
   endproperty
   a_irq_quiet: assert property (p_irq_quiet) else $error("irq without source");
   property p_wake;
      !fh_off_in |=> !wake_out;
   endproperty
   a_wake: assert property (p_wake) else $error("wake while clock runs");
   property p_ack;
      ack_out |=> !ack_out;
   endproperty
   a_ack: assert property (p_ack) else $error("ack held two cycles");
endmodule : uctl_top
`default_nettype wire

/* File: sim/uart_control_options_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module uart_control_options_bench import uctl_pkg::*;;
   logic        clk, rst_n, cyc, stb, we, fh_off, ack, irq, wake, tx, rxtx;
   logic [4:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, rdat;
   logic [7:0]  q;
   uctl_pins_s  pins;
   int          n_errors, checks_done;

   uctl_top u_dut (.clk_in(clk), .rst_n_in(rst_n), .cyc_in(cyc), .stb_in(stb), .we_in(we),
      .adr_in(adr), .sel_in(sel), .dat_in(wdat), .dat_out(rdat), .ack_out(ack),
      .rxtx_in(rxtx), .fh_off_in(fh_off), .pins_out(pins), .irq_out(irq), .wake_out(wake));
   uctl_remote u_remote (.pins_in(pins), .clk_in(clk), .tx_out(tx), .rxtx_out(rxtx));

   // Clock, 4 ns period
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_errors++;
         $display("wrong value %s expected %0h seen %0h", n, e, s);
      end
   endtask : chk

   // Classic single cycle, held until ack is sampled
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      int t;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h000000, d};
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (ack !== 1'b1 && t < 50);
      q = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      if (t >= 50) chk("ack", 0, 1);
      #1;
   endtask : bus

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [4:0] a);
      bus(1'b0, a, 8'h00);
   endtask : rd

   // Expected frame, fmt is {len, par, odd, stop2}
   function automatic logic [12:0] frm(input logic [8:0] d, input logic [3:0] fmt);
      logic [12:0] f;
      int k;
      f = '1;
      f[0] = 1'b0;
      k = 1;
      for (int i = 0; i < 8 + fmt[3]; i++) begin
         f[k] = d[i];
         k++;
      end
      if (fmt[2]) f[k] = ^(fmt[3] ? d : {1'b0, d[7:0]}) ^ fmt[1];
      return f;
   endfunction : frm

   // Sample the transmit wire at mid-bit after the start edge
   task automatic txcap(input int bl, input logic [8:0] d, input logic [3:0] fmt);
      logic [12:0] g;
      int t;
      g = '1;
      t = 0;
      while (tx !== 1'b0 && t < 2000) begin
         @(posedge clk);
         t++;
      end
      repeat (bl / 2) @(posedge clk);
      for (int i = 0; i < 10 + fmt[3] + fmt[2] + fmt[0]; i++) begin
         g[i] = tx;
         repeat (bl) @(posedge clk);
      end
      chk("frame", g, frm(d, fmt));
   endtask : txcap

   task automatic t_reset;
      rd(UCTL_CTRL1);
      chk("ctrl1", q & 8'hFD, 8'h00);
      rd(UCTL_STATUS);
      chk("status", q, 8'h0B);
      wr(5'h18, 8'hFF);
      rd(5'h18);
      chk("unmapped", q, 8'h00);
      wr(UCTL_CTRL1, 8'h01);
      rd(UCTL_CTRL1);
      chk("tx9 read", q & 8'hFD, 8'h00);
      chk("tx_oe", pins.tx_oe, 0);
   endtask : t_reset

   task automatic t_tx;
      logic [7:0] c1 [3] = '{8'h80, 8'hF9, 8'hA0};
      logic [7:0] c2 [3] = '{8'hA0, 8'h80, 8'hA0};
      logic [7:0] bd [3] = '{8'h01, 8'h00, 8'h00};
      logic [8:0] dd [3] = '{9'h04D, 9'h13C, 9'h007};
      int bl [3] = '{32, 64, 16};
      for (int i = 0; i < 3; i++) begin
         wr(UCTL_BAUD, bd[i]);
         wr(UCTL_CTRL1, c1[i]);
         wr(UCTL_CTRL2, c2[i]);
         wr(UCTL_DATA, dd[i][7:0]);
         txcap(bl[i], dd[i], c1[i][6:3]);
      end
   endtask : t_tx

   task automatic t_rx;
      wr(UCTL_CTRL1, 8'h80);
      wr(UCTL_CTRL2, 8'h64);
      u_remote.send(frm(9'h0A5, 4'h0), 10, 16);
      repeat (8) @(posedge clk);
      chk("irq", irq, 1);
      rd(UCTL_STATUS);
      rd(UCTL_DATA);
      chk("data", q, 8'hA5);
      chk("irq", irq, 0);
      wr(UCTL_CTRL1, 8'hC8);
      u_remote.send(frm(9'h13C, 4'h8), 11, 16);
      repeat (8) @(posedge clk);
      rd(UCTL_STATUS);
      chk("framing", q[5], 0);
      rd(UCTL_DATA);
      chk("data9", q, 8'h3C);
      rd(UCTL_CTRL1);
      chk("rx9", q, 8'hCA);
      wr(UCTL_CTRL1, 8'h80);
      wr(UCTL_CTRL2, 8'h74);
      u_remote.send(frm(9'h012, 4'h0), 10, 16);
      repeat (8) @(posedge clk);
      chk("irq", irq, 0);
      u_remote.send(frm(9'h092, 4'h0), 10, 16);
      repeat (8) @(posedge clk);
      chk("irq", irq, 1);
      rd(UCTL_STATUS);
      rd(UCTL_DATA);
      chk("address", q, 8'h92);
   endtask : t_rx

   // Bad parity word, then a second word with the first unread
   task automatic t_err;
      wr(UCTL_CTRL1, 8'hA0);
      wr(UCTL_CTRL2, 8'h64);
      u_remote.send(frm(9'h007, 4'h4) ^ 13'h0200, 11, 16);
      repeat (8) @(posedge clk);
      u_remote.send(frm(9'h008, 4'h4), 11, 16);
      repeat (8) @(posedge clk);
      chk("irq", irq, 1);
      rd(UCTL_STATUS);
      chk("status", q, 8'h9F);
      rd(UCTL_DATA);
      chk("kept data", q, 8'h07);
      chk("irq", irq, 0);
      rd(UCTL_STATUS);
      chk("status", q, 8'h0B);
   endtask : t_err

   task automatic t_brk;
      int t;
      int bad;
      wr(UCTL_CTRL2, 8'hA0);
      wr(UCTL_CTRL1, 8'h84);
      t = 0;
      bad = 0;
      while (tx !== 1'b0 && t < 100) begin
         @(posedge clk);
         t++;
      end
      repeat (13 * 16) begin
         @(posedge clk);
         if (tx !== 1'b0) bad++;
      end
      chk("break low", bad, 0);
      wr(UCTL_CTRL1, 8'h80);
      t = 0;
      while (tx !== 1'b1 && t < 100) begin
         @(posedge clk);
         t++;
      end
      chk("break end", tx, 1);
   endtask : t_brk

   task automatic t_off;
      wr(UCTL_BAUD, 8'h01);
      wr(UCTL_DATA, 8'h55);
      repeat (50) @(posedge clk);
      wr(UCTL_CTRL2, 8'h20);
      chk("tx_oe", pins.tx_oe, 0);
      wr(UCTL_CTRL2, 8'hE0);
      wr(UCTL_DATA, 8'h55);
      repeat (100) @(posedge clk);
      wr(UCTL_CTRL1, 8'h00);
      chk("tx_oe", pins.tx_oe, 0);
      rd(UCTL_CTRL2);
      chk("ctrl2", q, 8'h20);
      rd(UCTL_STATUS);
      chk("status", q, 8'h0B);
      rd(UCTL_BAUD);
      chk("baud", q, 8'h01);
      wr(UCTL_CTRL1, 8'h80);
      wr(UCTL_CTRL2, 8'hA0);
      repeat (40) @(posedge clk);
      chk("tx idle", tx, 1);
      wr(UCTL_DATA, 8'hC3);
      txcap(32, 9'h0C3, 4'h0);
   endtask : t_off

   task automatic t_wake;
      wr(UCTL_CTRL2, 8'h08);
      fh_off <= 1'b1;
      u_remote.send(13'h0000, 1, 4);
      repeat (4) @(posedge clk);
      chk("wake", wake, 1);
      fh_off <= 1'b0;
      u_remote.send(13'h0000, 1, 4);
      repeat (4) @(posedge clk);
      chk("wake", wake, 0);
   endtask : t_wake

   task automatic t_pins;
      wr(UCTL_CTRL3, 8'h01);
      wr(UCTL_CTRL2, 8'h80);
      chk("rxtx_oe", pins.rxtx_oe, 1);
      wr(UCTL_CTRL2, 8'hC0);
      chk("rxtx_oe", pins.rxtx_oe, 0);
      wr(UCTL_CTRL2, 8'h81);
      chk("irq", irq, 1);
      wr(UCTL_CTRL2, 8'h82);
      chk("irq", irq, 1);
      wr(UCTL_CTRL2, 8'h80);
      chk("irq", irq, 0);
      wr(UCTL_DATA, 8'h5A);
      repeat (2) @(posedge clk);
      chk("rxtx start", rxtx, 0);
      wr(UCTL_CTRL1, 8'h00);
      chk("rxtx_oe", pins.rxtx_oe, 0);
   endtask : t_pins

   task automatic end_sim;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim

   // Watchdog against a hang
   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      end_sim();
   end

   // Reset, then the scenarios in turn
   initial begin
      {rst_n, cyc, stb, we, fh_off} = 5'h00;
      adr = 5'h00;
      sel = 4'hF;
      wdat = 32'h00000000;
      n_errors = 0;
      checks_done = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_reset();
      t_tx();
      t_rx();
      t_err();
      t_brk();
      t_off();
      t_wake();
      t_pins();
      end_sim();
   end
endmodule : uart_control_options_bench
`default_nettype wire

/* File: sim/uctl_remote.sv */
`timescale 1ns/1ns
`default_nettype none
module uctl_remote import uctl_pkg::*; (
   input  wire uctl_pins_s pins_in,  // Device pin drives
   input  wire logic       clk_in,   // System clock
   output logic            tx_out,   // Transmit wire level
   output logic            rxtx_out  // Shared wire level
);
   logic drv;

   initial drv = 1'b1;
   // Released wires rest high through pull-ups
   assign tx_out   = pins_in.tx_oe ? pins_in.tx_out : 1'b1;
   assign rxtx_out = pins_in.rxtx_oe ? pins_in.rxtx_out : drv;

   // Frame sent LSB first, one bit period per bit, one stop only
   task automatic send(input logic [12:0] f, input int n, input int bl);
      for (int i = 0; i < n; i++) begin
         drv <= f[i];
         repeat (bl) @(posedge clk_in);
      end
      drv <= 1'b1;
   endtask : send
endmodule : uctl_remote
`default_nettype wire
